// ### logic/bus_node_switch_config.sv
// Purpose: Turns address and rate switches into the node's serial bus setup
// Assumes: Switch pins are asynchronous; UART and frame parser sit on aclk
// Notes: Stored address and custom rate live in registers until reset
//
// Design decisions made here: the AXI4-Lite register port and the address map.

// What this block does
// - Five address switches form binary node address
// - Node address zero never answers
// - All address switches off uses stored address
// - Rate switches pick 9600, 19200, 38400, 115200
// - Both on uses stored custom rate, else 9600
// - Half duplex; driver off after each transmission
// - Frames use configured address and bit rate
module bus_node_switch_config #(
	parameter int unsigned SETTLE_CYC = node_cfg_pkg::SWITCH_SETTLE_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Switch pins
	input wire logic [node_cfg_pkg::ADDR_SW_W-1:0] node_address_switches,
	input wire logic [node_cfg_pkg::RATE_SW_W-1:0] bit_rate_select_switches,
	// AXI4-Lite write
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Frame parser side
	input wire logic frame_addr_valid,
	input wire logic [node_cfg_pkg::NODE_W-1:0] frame_addr,
	output logic frame_addr_match,
	// Transmitter side
	input wire logic tx_request,
	input wire logic tx_done,
	input wire logic rx_busy,
	output logic tx_grant,
	output logic driver_enable,
	// Configuration out
	output node_cfg_pkg::cfg_t cfg,
	output logic bit_tick
);

	// ----------------------------------------------------------------
	// Switch synchronisers
	// ----------------------------------------------------------------
	localparam int unsigned SW_W = node_cfg_pkg::ADDR_SW_W + node_cfg_pkg::RATE_SW_W;

	logic [SW_W-1:0] sw_s1_ff, sw_s2_ff, sw_s3_ff, sw_filt_ff;
	logic [SW_W-1:0] nxt_sw_filt;

	// Bit changes only when stages two and three agree; rejects bounce
	always_comb begin
		nxt_sw_filt = sw_filt_ff;
		for (int i = 0; i < SW_W; i++) begin
			if (sw_s2_ff[i] == sw_s3_ff[i]) begin
				nxt_sw_filt[i] = sw_s3_ff[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_s1_ff <= '0;
			sw_s2_ff <= '0;
			sw_s3_ff <= '0;
			sw_filt_ff <= '0;
		end else begin
			sw_s1_ff <= {bit_rate_select_switches, node_address_switches};
			sw_s2_ff <= sw_s1_ff;
			sw_s3_ff <= sw_s2_ff;
			sw_filt_ff <= nxt_sw_filt;
		end
	end

	// ----------------------------------------------------------------
	// One-time snapshot after reset
	// ----------------------------------------------------------------
	localparam int unsigned SETTLE_W = $clog2(SETTLE_CYC + 1);

	node_cfg_pkg::snap_state_t snap_ff, nxt_snap;
	logic [SETTLE_W-1:0] settle_ff, nxt_settle;
	logic [SW_W-1:0] snap_sw_ff, nxt_snap_sw;

	// Settle wait lets the synchroniser fill before the value is frozen
	always_comb begin
		nxt_snap = snap_ff;
		nxt_settle = settle_ff;
		nxt_snap_sw = snap_sw_ff;
		case (snap_ff)
			node_cfg_pkg::SNAP_SETTLE: begin
				if (settle_ff == SETTLE_W'(SETTLE_CYC - 1)) begin
					nxt_snap_sw = sw_filt_ff;
					nxt_snap = node_cfg_pkg::SNAP_LOCKED;
				end else begin
					nxt_settle = SETTLE_W'(settle_ff + 1'b1);
				end
			end
			node_cfg_pkg::SNAP_LOCKED: begin
				nxt_snap = node_cfg_pkg::SNAP_LOCKED;
			end
			default: begin
				nxt_snap = node_cfg_pkg::SNAP_SETTLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			snap_ff <= node_cfg_pkg::SNAP_SETTLE;
			settle_ff <= '0;
			snap_sw_ff <= '0;
		end else begin
			snap_ff <= nxt_snap;
			settle_ff <= nxt_settle;
			snap_sw_ff <= nxt_snap_sw;
		end
	end

	// ----------------------------------------------------------------
	// Host-written registers over AXI4-Lite
	// ----------------------------------------------------------------
	logic [node_cfg_pkg::NODE_W-1:0] stored_addr_ff, nxt_stored_addr;
	logic [node_cfg_pkg::RATE_W-1:0] custom_rate_ff, nxt_custom_rate;
	logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
	logic [3:0] aw_addr_ff, nxt_aw_addr;
	logic [31:0] w_data_ff, nxt_w_data;
	logic [3:0] w_strb_ff, nxt_w_strb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [1:0] rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [31:0] status_word, wmerged;
	// Declared here because the read path returns the live effective rate
	node_cfg_pkg::cfg_t cfg_ff, nxt_cfg;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic known_reg(input logic [3:0] a);
		return a == node_cfg_pkg::REG_STORED_ADDR || a == node_cfg_pkg::REG_CUSTOM_RATE ||
			a == node_cfg_pkg::REG_STATUS || a == node_cfg_pkg::REG_EFFECTIVE_RATE;
	endfunction

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;

	always_comb begin
		nxt_aw_held = aw_held_ff;
		nxt_w_held = w_held_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_data = w_data_ff;
		nxt_w_strb = w_strb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_stored_addr = stored_addr_ff;
		nxt_custom_rate = custom_rate_ff;
		wmerged = '0;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_held = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_held = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_strb = s_axi_wstrb;
		end
		if (aw_held_ff && w_held_ff) begin
			nxt_aw_held = 1'b0;
			nxt_w_held = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = node_cfg_pkg::RESP_OKAY;
			case (aw_addr_ff)
				node_cfg_pkg::REG_STORED_ADDR: begin
					wmerged = merge_bytes(32'(stored_addr_ff), w_data_ff, w_strb_ff);
					nxt_stored_addr = wmerged[node_cfg_pkg::NODE_W-1:0];
				end
				node_cfg_pkg::REG_CUSTOM_RATE: begin
					wmerged = merge_bytes(32'(custom_rate_ff), w_data_ff, w_strb_ff);
					nxt_custom_rate = wmerged[node_cfg_pkg::RATE_W-1:0];
				end
				default: begin
					if (!known_reg(aw_addr_ff)) begin
						nxt_bresp = node_cfg_pkg::RESP_SLVERR;
					end
				end
			endcase
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
	end

	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = known_reg(s_axi_araddr) ? node_cfg_pkg::RESP_OKAY : node_cfg_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				node_cfg_pkg::REG_STORED_ADDR: nxt_rdata = 32'(stored_addr_ff);
				node_cfg_pkg::REG_CUSTOM_RATE: nxt_rdata = 32'(custom_rate_ff);
				node_cfg_pkg::REG_STATUS: nxt_rdata = status_word;
				node_cfg_pkg::REG_EFFECTIVE_RATE: nxt_rdata = 32'(cfg_ff.bit_rate);
				default: nxt_rdata = '0;
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff <= node_cfg_pkg::RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= node_cfg_pkg::RESP_OKAY;
			rdata_ff <= '0;
			stored_addr_ff <= node_cfg_pkg::NODE_RST;
			custom_rate_ff <= node_cfg_pkg::CUSTOM_RATE_RST;
		end else begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff <= nxt_w_held;
			aw_addr_ff <= nxt_aw_addr;
			w_data_ff <= nxt_w_data;
			w_strb_ff <= nxt_w_strb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
			stored_addr_ff <= nxt_stored_addr;
			custom_rate_ff <= nxt_custom_rate;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	// ----------------------------------------------------------------
	// Configuration decode
	// ----------------------------------------------------------------
	logic [node_cfg_pkg::ADDR_SW_W-1:0] snap_addr;
	logic [node_cfg_pkg::RATE_SW_W-1:0] snap_rate;

	assign snap_addr = snap_sw_ff[node_cfg_pkg::ADDR_SW_W-1:0];
	assign snap_rate = snap_sw_ff[SW_W-1:node_cfg_pkg::ADDR_SW_W];

	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_cfg.locked = (snap_ff == node_cfg_pkg::SNAP_LOCKED);
		nxt_cfg.rate_sel = snap_rate;
		nxt_cfg.addr_from_switches = (snap_addr != node_cfg_pkg::ADDR_SW_ALL_OFF);
		nxt_cfg.custom_rate_active = 1'b0;
		if (snap_addr != node_cfg_pkg::ADDR_SW_ALL_OFF) begin
			nxt_cfg.node_address = node_cfg_pkg::NODE_W'(snap_addr);
		end else begin
			nxt_cfg.node_address = stored_addr_ff;
		end
		case (snap_rate)
			node_cfg_pkg::RATE_SEL_BOTH_ON: begin
				if (custom_rate_ff != node_cfg_pkg::CUSTOM_RATE_RST) begin
					nxt_cfg.bit_rate = custom_rate_ff;
					nxt_cfg.custom_rate_active = 1'b1;
				end else begin
					nxt_cfg.bit_rate = node_cfg_pkg::RATE_9600;
				end
			end
			node_cfg_pkg::RATE_SEL_UPPER_ON: nxt_cfg.bit_rate = node_cfg_pkg::RATE_19200;
			node_cfg_pkg::RATE_SEL_LOWER_ON: nxt_cfg.bit_rate = node_cfg_pkg::RATE_38400;
			node_cfg_pkg::RATE_SEL_BOTH_OFF: nxt_cfg.bit_rate = node_cfg_pkg::RATE_115200;
			default: nxt_cfg.bit_rate = node_cfg_pkg::RATE_9600;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff <= '0;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	assign cfg = cfg_ff;

	always_comb begin
		status_word = '0;
		status_word[node_cfg_pkg::NODE_W-1:0] = cfg_ff.node_address;
		status_word[node_cfg_pkg::ST_SEL_LSB +: node_cfg_pkg::RATE_SW_W] = cfg_ff.rate_sel;
		status_word[node_cfg_pkg::ST_FROM_SW_BIT] = cfg_ff.addr_from_switches;
		status_word[node_cfg_pkg::ST_LOCKED_BIT] = cfg_ff.locked;
		status_word[node_cfg_pkg::ST_CUSTOM_BIT] = cfg_ff.custom_rate_active;
		status_word[node_cfg_pkg::ST_ADDR_VALID_BIT] = (cfg_ff.node_address != node_cfg_pkg::NODE_RESERVED);
	end

	// ----------------------------------------------------------------
	// Address match and bit-rate tick
	// ----------------------------------------------------------------
	logic match_ff, nxt_match;

	// Zero is never ours, so a stored zero leaves the node silent
	always_comb begin
		nxt_match = frame_addr_valid && cfg_ff.locked && frame_addr == cfg_ff.node_address &&
			cfg_ff.node_address != node_cfg_pkg::NODE_RESERVED;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_ff <= 1'b0;
		end else begin
			match_ff <= nxt_match;
		end
	end

	assign frame_addr_match = match_ff;

	logic [27:0] tick_step;
	assign tick_step = 28'(cfg_ff.bit_rate) * 28'(node_cfg_pkg::OVERSAMPLE);

	// Oversampled tick at the configured rate drives the UART
	rate_tick_gen #(
		.MODULUS(node_cfg_pkg::CLK_HZ),
		.ACC_W(28)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(cfg_ff.locked),
		.step(tick_step),
		.tick(bit_tick)
	);

	// ----------------------------------------------------------------
	// Half-duplex driver control
	// ----------------------------------------------------------------
	node_cfg_pkg::drv_state_t drv_ff, nxt_drv;

	// Driver only turns on while the receiver sees a quiet line
	always_comb begin
		nxt_drv = drv_ff;
		case (drv_ff)
			node_cfg_pkg::DRV_IDLE: begin
				if (tx_request && cfg_ff.locked) begin
					nxt_drv = node_cfg_pkg::DRV_WAIT;
				end
			end
			node_cfg_pkg::DRV_WAIT: begin
				if (!rx_busy) begin
					nxt_drv = node_cfg_pkg::DRV_ON;
				end
			end
			node_cfg_pkg::DRV_ON: begin
				if (tx_done) begin
					nxt_drv = node_cfg_pkg::DRV_RELEASE;
				end
			end
			node_cfg_pkg::DRV_RELEASE: begin
				nxt_drv = node_cfg_pkg::DRV_IDLE;
			end
			default: begin
				nxt_drv = node_cfg_pkg::DRV_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drv_ff <= node_cfg_pkg::DRV_IDLE;
		end else begin
			drv_ff <= nxt_drv;
		end
	end

	assign driver_enable = (drv_ff == node_cfg_pkg::DRV_ON);
	assign tx_grant = (drv_ff == node_cfg_pkg::DRV_ON);

endmodule // bus_node_switch_config

// ### logic/node_cfg_pkg.sv
// Purpose: Shared constants and types for the bus node switch configuration block
// Assumes: 125 MHz aclk, AXI4-Lite register access, switch pin high means ON
// Notes: Register offsets are byte addresses of aligned 32-bit words
package node_cfg_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned SWITCH_SETTLE_US = 1000;
	localparam int unsigned SWITCH_SETTLE_CYC = SWITCH_SETTLE_US * CLK_MHZ;
	localparam int unsigned OVERSAMPLE = 16;

	// ----------------------------------------------------------------
	// Widths and field values
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_SW_W = 5;
	localparam int unsigned RATE_SW_W = 2;
	localparam int unsigned NODE_W = 8;
	localparam int unsigned RATE_W = 24;
	localparam logic [ADDR_SW_W-1:0] ADDR_SW_ALL_OFF = 5'h00;
	localparam logic [NODE_W-1:0] NODE_RESERVED = 8'h00;
	localparam logic [NODE_W-1:0] NODE_RST = 8'h00;
	localparam logic [RATE_W-1:0] CUSTOM_RATE_RST = 24'h000000;

	// Rate switch codes: bit 1 is the upper switch, bit 0 the lower
	localparam logic [RATE_SW_W-1:0] RATE_SEL_BOTH_ON = 2'h3;
	localparam logic [RATE_SW_W-1:0] RATE_SEL_UPPER_ON = 2'h2;
	localparam logic [RATE_SW_W-1:0] RATE_SEL_LOWER_ON = 2'h1;
	localparam logic [RATE_SW_W-1:0] RATE_SEL_BOTH_OFF = 2'h0;
	localparam logic [RATE_W-1:0] RATE_9600 = 24'h002580;
	localparam logic [RATE_W-1:0] RATE_19200 = 24'h004b00;
	localparam logic [RATE_W-1:0] RATE_38400 = 24'h009600;
	localparam logic [RATE_W-1:0] RATE_115200 = 24'h01c200;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_STORED_ADDR = 4'h0;
	localparam logic [3:0] REG_CUSTOM_RATE = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_EFFECTIVE_RATE = 4'hc;
	localparam int unsigned ST_SEL_LSB = 8;
	localparam int unsigned ST_FROM_SW_BIT = 10;
	localparam int unsigned ST_LOCKED_BIT = 11;
	localparam int unsigned ST_CUSTOM_BIT = 12;
	localparam int unsigned ST_ADDR_VALID_BIT = 13;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic locked;
		logic addr_from_switches;
		logic custom_rate_active;
		logic [RATE_SW_W-1:0] rate_sel;
		logic [NODE_W-1:0] node_address;
		logic [RATE_W-1:0] bit_rate;
	} cfg_t;

	typedef enum logic [1:0] {
		SNAP_SETTLE = 2'b01,
		SNAP_LOCKED = 2'b10
	} snap_state_t;

	typedef enum logic [3:0] {
		DRV_IDLE = 4'b0001,
		DRV_WAIT = 4'b0010,
		DRV_ON = 4'b0100,
		DRV_RELEASE = 4'b1000
	} drv_state_t;

endpackage

// ### logic/rate_tick_gen.sv
// Purpose: Phase accumulator that emits one-cycle pulses at a programmable rate
// Assumes: step below modulus
// Notes: No divider needed; mean rate is exact, jitter is one clock
module rate_tick_gen #(
	parameter int unsigned MODULUS = 125_000_000,
	parameter int unsigned ACC_W = 28
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Rate control
	input wire logic run,
	input wire logic [ACC_W-1:0] step,
	// Tick out
	output logic tick
);

	localparam logic [ACC_W-1:0] MOD_V = ACC_W'(MODULUS);

	logic [ACC_W-1:0] acc_ff;
	logic [ACC_W-1:0] nxt_acc;
	logic tick_ff;
	logic nxt_tick;
	logic [ACC_W:0] sum;

	always_comb begin
		sum = {1'b0, acc_ff} + {1'b0, step};
		nxt_acc = acc_ff;
		nxt_tick = 1'b0;
		if (!run) begin
			nxt_acc = '0;
		end else if (sum >= {1'b0, MOD_V}) begin
			nxt_acc = ACC_W'(sum - {1'b0, MOD_V});
			nxt_tick = 1'b1;
		end else begin
			nxt_acc = sum[ACC_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			acc_ff <= nxt_acc;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;

endmodule // rate_tick_gen

// ### test/node_bus_host_model.sv
// Purpose: Host controller on the shared half-duplex bus
// Assumes: One drive on this segment
// Notes: Released address byte is inverted so no stale value lingers
module node_bus_host_model (
	// Clock
	input wire logic aclk,
	// Frame parser side
	output logic frame_addr_valid,
	output logic [node_cfg_pkg::NODE_W-1:0] frame_addr,
	input wire logic frame_addr_match,
	// Transmitter side
	output logic tx_request,
	output logic tx_done,
	output logic rx_busy,
	input wire logic driver_enable
);
	localparam int MAX_DRIVES = 30;
	localparam int DRIVES = 1;
	initial begin
		frame_addr_valid = 1'b0;
		frame_addr = 8'h5a;
		tx_request = 1'b0;
		tx_done = 1'b0;
		rx_busy = 1'b0;
	end
	// One request frame address byte
	task automatic poll(input logic [7:0] a, output logic hit);
		@(posedge aclk);
		frame_addr_valid <= 1'b1;
		frame_addr <= a;
		@(posedge aclk);
		frame_addr_valid <= 1'b0;
		frame_addr <= ~a;
		#1 hit = frame_addr_match;
	endtask
	// Host keeps talking busy cycles; drive answers for len cycles
	task automatic reply(input int busy, input int len, output logic early, output logic got, output logic off);
		int n;
		early = 1'b0;
		n = 0;
		@(posedge aclk);
		tx_request <= 1'b1;
		rx_busy <= (busy != 0);
		@(posedge aclk);
		tx_request <= 1'b0;
		while (driver_enable !== 1'b1 && n < busy + 40) begin
			@(posedge aclk);
			if (n >= busy) rx_busy <= 1'b0;
			if (driver_enable && rx_busy) early = 1'b1;
			n++;
		end
		got = driver_enable;
		repeat (len) @(posedge aclk);
		tx_done <= 1'b1;
		@(posedge aclk);
		tx_done <= 1'b0;
		#1 off = driver_enable;
	endtask
endmodule // node_bus_host_model

// ### test/node_cfg_properties.sv
// Purpose: Port-level checks on the switch configuration block
// Assumes: One aclk domain, aresetn synchronous and active low
// Notes: Bound to the design from the testbench top file
module node_cfg_properties (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Frame and transmitter side
	input wire logic frame_addr_valid,
	input wire logic [node_cfg_pkg::NODE_W-1:0] frame_addr,
	input wire logic frame_addr_match,
	input wire logic tx_done,
	input wire logic rx_busy,
	input wire logic tx_grant,
	input wire logic driver_enable,
	// Configuration
	input wire node_cfg_pkg::cfg_t cfg,
	input wire logic bit_tick
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	// Release cycle, then idle: line stays free two cycles
	sequence s_line_free;
		!driver_enable ##1 !driver_enable;
	endsequence

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_zero_silent: assert property (frame_addr_valid && frame_addr == node_cfg_pkg::NODE_RESERVED |=> !frame_addr_match)
		else $error("match on address zero");
	a_match_cause: assert property (frame_addr_match |-> $past(frame_addr_valid) && cfg.locked && cfg.node_address != 0
		&& $past(frame_addr) == cfg.node_address)
		else $error("match without own address");
	a_match_hit: assert property (frame_addr_valid && cfg.locked && cfg.node_address != 0
		&& frame_addr == cfg.node_address |=> frame_addr_match)
		else $error("own address missed");
	a_switch_held: assert property ($past(cfg.locked) && cfg.locked |-> cfg.locked && $stable(cfg.rate_sel)
		&& $stable(cfg.addr_from_switches) && (!cfg.addr_from_switches || $stable(cfg.node_address)))
		else $error("switch snapshot moved");
	a_switch_range: assert property (cfg.locked && cfg.addr_from_switches |-> cfg.node_address inside {[1:31]})
		else $error("switch address out of range");
	a_rate_table: assert property (cfg.locked && !cfg.custom_rate_active |-> cfg.bit_rate ==
		(cfg.rate_sel == 2'h3 ? node_cfg_pkg::RATE_9600 : cfg.rate_sel == 2'h2 ? node_cfg_pkg::RATE_19200 :
		cfg.rate_sel == 2'h1 ? node_cfg_pkg::RATE_38400 : node_cfg_pkg::RATE_115200))
		else $error("bit rate off table");
	a_custom_both: assert property (cfg.custom_rate_active |-> cfg.rate_sel == node_cfg_pkg::RATE_SEL_BOTH_ON)
		else $error("custom rate without both on");
	a_line_release: assert property (tx_done && driver_enable |=> s_line_free)
		else $error("driver held after done");
	a_drive_free: assert property ($rose(driver_enable) |-> tx_grant && !$past(rx_busy))
		else $error("driver on over busy line");
	a_tick_locked: assert property (bit_tick |-> cfg.locked)
		else $error("tick before lock");
endmodule // node_cfg_properties

// ### test/testbench.sv
// Purpose: Self-checking bench for the switch configuration block
// Assumes: Settle count shortened to 8 cycles
// Notes: Each pass resets with new switches, then moves them
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [4:0] addr_sw = 5'h00;
	logic [1:0] rate_sw = 2'h0;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire awready, wready, bvalid, arready, rvalid, fav, fam, txr, txd, rxb, grant, drv, tick;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] fa;
	node_cfg_pkg::cfg_t cfg;
	int err_count = 0, check_count = 0, seed = 80827, cyc = 0, ticks = 0;

	bus_node_switch_config #(.SETTLE_CYC(8)) dut (.aclk(aclk), .aresetn(aresetn),
		.node_address_switches(addr_sw), .bit_rate_select_switches(rate_sw),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .frame_addr_valid(fav), .frame_addr(fa), .frame_addr_match(fam),
		.tx_request(txr), .tx_done(txd), .rx_busy(rxb), .tx_grant(grant), .driver_enable(drv),
		.cfg(cfg), .bit_tick(tick));
	node_bus_host_model host (.aclk(aclk), .frame_addr_valid(fav), .frame_addr(fa), .frame_addr_match(fam),
		.tx_request(txr), .tx_done(txd), .rx_busy(rxb), .driver_enable(drv));

	always #4 aclk = ~aclk;
	// Watchdog and tick counter
	always @(posedge aclk) begin
		cyc++;
		if (tick === 1'b1) ticks++;
		if (cyc == 40000) begin
			err_count++;
			end_sim;
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				got = 1'b1;
			end
		end
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				got = 1'b1;
			end
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int i, n, node, rate, st;
		longint ex;
		logic [4:0] sw;
		logic [7:0] stored;
		logic [23:0] cust;
		logic [31:0] d;
		logic [1:0] r;
		logic hit, early, got, off;
		for (i = 0; i < 8; i++) begin
			stored = (i == 1) ? 8'h00 : 8'($random(seed));
			cust = i[2] ? ((24'($random(seed)) & 24'h0fffff) | 24'h000001) : 24'h000000;
			sw = (i == 2) ? 5'h1f : (i == 3) ? 5'h01 : (i < 2) ? 5'h00 : 5'($random(seed));
			@(posedge aclk);
			aresetn <= 1'b0;
			addr_sw <= sw;
			rate_sw <= 2'(i);
			repeat (12) @(posedge aclk);
			aresetn <= 1'b1;
			axi_wr(node_cfg_pkg::REG_STORED_ADDR, {24'h0, stored}, r);
			axi_wr(node_cfg_pkg::REG_CUSTOM_RATE, {8'h0, cust}, r);
			axi_wr(node_cfg_pkg::REG_STATUS, 32'hffffffff, r);
			check(r, node_cfg_pkg::RESP_OKAY);
			axi_wr(4'h2, 32'h0, r);
			check(r, node_cfg_pkg::RESP_SLVERR);
			n = 0;
			while (cfg.locked !== 1'b1 && n < 100) begin
				@(posedge aclk);
				n++;
			end
			check(cfg.locked, 1);
			addr_sw <= 5'($random(seed));
			rate_sw <= 2'($random(seed));
			node = (sw != 0) ? sw : stored;
			rate = (i % 4 == 3) ? ((cust != 0) ? cust : 9600) : (i % 4 == 2) ? 19200 : (i % 4 == 1) ? 38400 : 115200;
			st = node | (i % 4) << 8 | (sw != 0) << 10 | 1 << 11 | (i % 4 == 3 && cust != 0) << 12 | (node != 0) << 13;
			axi_rd(node_cfg_pkg::REG_STATUS, d, r);
			check(d, st);
			axi_rd(node_cfg_pkg::REG_EFFECTIVE_RATE, d, r);
			check(d, rate);
			axi_rd(node_cfg_pkg::REG_STORED_ADDR, d, r);
			check(d, stored);
			axi_rd(4'h6, d, r);
			check(r, node_cfg_pkg::RESP_SLVERR);
			check(cfg.node_address, node);
			host.poll(8'(node), hit);
			check(hit, node != 0);
			host.poll(8'h00, hit);
			check(hit, 0);
			host.poll(8'(node) ^ 8'h20, hit);
			check(hit, 0);
			host.reply(i, 3 + i, early, got, off);
			check({early, got, off}, 3'b010);
			#1 ticks = 0;
			repeat (2000) @(posedge aclk);
			ex = longint'(2000) * 16 * rate / 125000000;
			#1 check(ticks >= ex && ticks <= ex + 1, 1);
			$display("pass %0d done", i);
		end
		end_sim;
	end
endmodule // testbench

bind bus_node_switch_config node_cfg_properties u_props (.aclk(aclk), .aresetn(aresetn),
	.frame_addr_valid(frame_addr_valid), .frame_addr(frame_addr), .frame_addr_match(frame_addr_match),
	.tx_done(tx_done), .rx_busy(rx_busy), .tx_grant(tx_grant), .driver_enable(driver_enable),
	.cfg(cfg), .bit_tick(bit_tick));
